// >>> hw/ddrcm_pkg.sv
// Purpose: Shared constants and types for the DDR command and mode logic.
// Assumes: One 100 MHz clock; AXI4-Lite register access with 32-bit data.
// Notes: Mode field codes follow the usual DDR encodings.
package ddrcm_pkg;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int ROW_W = 13;
  localparam int BANKS = 4;
  // Command pins as sampled from the controller.
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic dm;
    logic [1:0] ba;
    logic [ADDR_W-1:0] addr;
  } ddrcm_cmd_s;
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BT, CMD_PRE, CMD_REF, CMD_SREF, CMD_LMR
  } ddrcm_cmd_e;
  // Base mode register fields.
  localparam int MR_BL_LSB = 0;
  localparam int MR_BT_BIT = 3;
  localparam int MR_LAT_LSB = 4;
  localparam int MR_OP_LSB = 7;
  localparam int MR_DLLRST_BIT = 8;
  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] LAT_CODE_2 = 3'h2;
  localparam logic [2:0] LAT_CODE_25 = 3'h6;
  localparam logic [5:0] OP_NORMAL = 6'h00;
  localparam logic [5:0] OP_DLLRST = 6'h02;
  localparam int AUTO_PRE_BIT = 10;
  localparam int EMR_DLL_DIS_BIT = 0;
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h1;
  localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] EXT_RST = 13'h0001;
  // Clock cycles before a READ after the DLL is enabled.
  localparam int DLL_WAIT_CYC = 200;
  // Register map, byte addresses.
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STAT = 5'h04;
  localparam logic [4:0] OFF_MODE = 5'h08;
  localparam logic [4:0] OFF_EXT = 5'h0C;
  localparam logic [4:0] OFF_ERR = 5'h10;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam int ERR_IDLE = 0;
  localparam int ERR_BT = 1;
  localparam int ERR_MODE = 2;
  localparam int ERR_DLL = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> hw/ddrcm_decode.sv
// Purpose: Decode the command strobes into one command kind.
// Assumes: Inputs are already synchronised to aclk.
// Notes: Purely combinational.
`timescale 1ns/1ps
module ddrcm_decode
  import ddrcm_pkg::*;
(
  input wire ddrcm_pkg::ddrcm_cmd_s cmd,
  output ddrcm_pkg::ddrcm_cmd_e kind
);
  wire [2:0] rcw = {cmd.ras_n, cmd.cas_n, cmd.we_n};
  always_comb begin
    kind = CMD_NOP;
    if (!cmd.cs_n) begin
      unique case (rcw)
        3'h3: kind = CMD_ACT;
        3'h5: kind = CMD_RD;
        3'h4: kind = CMD_WR;
        3'h6: kind = CMD_BT;
        3'h2: kind = CMD_PRE;
        3'h1: kind = cmd.cke ? CMD_REF : CMD_SREF;
        3'h0: kind = CMD_LMR;
        default: kind = CMD_NOP;
      endcase
    end
  end
endmodule

// >>> hw/ddrcm_burst.sv
// Purpose: Column sequencer for one burst, sequential or interleaved.
// Assumes: start is a one-cycle pulse; a new start restarts the burst.
// Notes: One column per clock; the beat column is valid while busy is high.
`timescale 1ns/1ps
module ddrcm_burst
  import ddrcm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire logic stop,
  input wire logic [2:0] len_mask,
  input wire logic interleave,
  input wire logic [ddrcm_pkg::COL_W-1:0] col,
  output logic busy,
  output logic last,
  output logic [ddrcm_pkg::COL_W-1:0] beat_col
);
  logic [COL_W-1:0] col_reg;
  logic [2:0] mask_reg, cnt_reg;
  logic il_reg;
  wire [2:0] start_lo = col_reg[2:0];
  wire [2:0] seq_off = start_lo + cnt_reg;
  wire [2:0] il_off = start_lo ^ cnt_reg;
  wire [2:0] off = il_reg ? il_off : seq_off;
  assign beat_col = {col_reg[COL_W-1:3], (start_lo & ~mask_reg) | (off & mask_reg)};
  assign last = busy && (cnt_reg == mask_reg);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      cnt_reg <= 3'h0;
      col_reg <= '0;
      mask_reg <= 3'h0;
      il_reg <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      cnt_reg <= 3'h0;
      col_reg <= col;
      mask_reg <= len_mask;
      il_reg <= interleave;
    end else if (stop || last) begin
      busy <= 1'b0;
    end else if (busy) begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
  a_burst_eight: assert property (@(posedge aclk) disable iff (!aresetn || stop)
    start && len_mask == 3'h7 |=> busy [*8])
    else $error("burst of eight ended early");
  a_seq_step: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && $past(busy) && !$past(start) && !il_reg
      |-> seq_off == $past(seq_off) + 3'h1)
    else $error("sequential order did not step by one");
  a_upper_fixed: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && !start ##1 busy |-> beat_col[COL_W-1:3] == $past(beat_col[COL_W-1:3]))
    else $error("upper column bits changed inside a burst");
endmodule

// >>> hw/ddrcm_top.sv
// Purpose: Command decode, bank state, burst order and mode registers of a DDR rank.
// Assumes: Command pins arrive asynchronously and are synchronised here.
// Notes: Latencies count from the synchronised command; 2.5 is served as 3 cycles.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
module ddrcm_top
  import ddrcm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ddrcm_pkg::ddrcm_cmd_s cmd_pins,
  output logic [1:0] mem_bank,
  output logic [ddrcm_pkg::COL_W-1:0] mem_col,
  output logic mem_rd,
  output logic mem_wr,
  output logic mem_act,
  output logic [ddrcm_pkg::ROW_W-1:0] mem_row,
  output logic mem_ref,
  output logic dll_reset,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import ddrcm_pkg::*;
  ddrcm_cmd_s sync1_reg, sync2_reg;
  ddrcm_cmd_e kind;
  logic [BANKS-1:0] open_reg;
  logic [ADDR_W-1:0] mode_reg, ext_reg;
  logic [ROW_W-1:0] ref_cnt_reg;
  logic [7:0] dll_cnt_reg;
  logic self_ref_reg, ctrl_en_reg, ap_reg, is_rd_reg, rd_dly_reg;
  logic [1:0] bbank_reg;
  logic [COL_W-1:0] col_dly_reg;
  logic [1:0] bank_dly_reg;
  logic [3:0] err_reg, wstrb_reg;
  logic busy, last;
  logic [COL_W-1:0] beat_col;
  logic aw_hold_reg, w_hold_reg;
  logic [4:0] awaddr_reg;
  logic [31:0] wdata_reg;

  // Two-stage synchroniser; only the second stage is decoded.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= '1;
      sync2_reg <= '1;
    end else begin
      sync1_reg <= cmd_pins;
      sync2_reg <= sync1_reg;
    end
  end

  ddrcm_decode u_dec (
    .cmd(sync2_reg),
    .kind(kind)
  );

  wire [1:0] ba = sync2_reg.ba;
  wire [ADDR_W-1:0] a = sync2_reg.addr;
  wire live = ctrl_en_reg && !self_ref_reg;
  wire c_act = live && kind == CMD_ACT;
  wire c_rd = live && kind == CMD_RD;
  wire c_wr = live && kind == CMD_WR;
  wire c_bt = live && kind == CMD_BT;
  wire c_pre = live && kind == CMD_PRE;
  wire c_ref = live && kind == CMD_REF;
  wire c_sref = live && kind == CMD_SREF;
  wire c_lmr = live && kind == CMD_LMR;
  wire bank_ok = open_reg[ba];
  wire dll_ready = !ext_reg[EMR_DLL_DIS_BIT] && dll_cnt_reg == 8'h00;
  wire rd_go = c_rd && bank_ok;
  wire wr_go = c_wr && bank_ok;
  wire bt_ok = c_bt && busy && is_rd_reg && !ap_reg;
  wire [5:0] op_mode = a[ADDR_W-1:MR_OP_LSB];
  wire lmr_base = c_lmr && ba == BA_MODE;
  wire lmr_ext = c_lmr && ba == BA_EXT;
  wire mode_ok = op_mode == OP_NORMAL || op_mode == OP_DLLRST;
  wire dll_rst_go = lmr_base && op_mode == OP_DLLRST;
  wire dll_on_go = lmr_ext && !a[EMR_DLL_DIS_BIT] && ext_reg[EMR_DLL_DIS_BIT];
  wire sref_exit = self_ref_reg && sync2_reg.cke;
  wire dll_load = dll_rst_go || dll_on_go || sref_exit;
  wire ap_close = last && ap_reg;
  wire [2:0] bl_code = mode_reg[MR_BL_LSB +: 3];
  wire [2:0] len_mask = bl_code == BL_CODE_8 ? 3'h7 : bl_code == BL_CODE_4 ? 3'h3 : 3'h1;
  wire lat_long = mode_reg[MR_LAT_LSB +: 3] == LAT_CODE_25;
  wire [3:0] err_set = {c_rd && !dll_ready, c_lmr && (!mode_ok || ba[1]),
                        c_bt && !bt_ok, (c_rd || c_wr) && !bank_ok};

  ddrcm_burst u_burst (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(rd_go || wr_go),
    .stop(bt_ok),
    .len_mask(len_mask),
    .interleave(mode_reg[MR_BT_BIT]),
    .col(a[COL_W-1:0]),
    .busy(busy),
    .last(last),
    .beat_col(beat_col)
  );

  // Bank state and burst attributes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_reg <= '0;
      ap_reg <= 1'b0;
      is_rd_reg <= 1'b0;
      bbank_reg <= 2'h0;
    end else begin
      if (rd_go || wr_go) begin
        ap_reg <= a[AUTO_PRE_BIT];
        is_rd_reg <= c_rd;
        bbank_reg <= ba;
      end
      if (c_pre && a[AUTO_PRE_BIT]) begin
        open_reg <= '0;
      end else if (c_pre) begin
        open_reg[ba] <= 1'b0;
      end else if (c_act) begin
        open_reg[ba] <= 1'b1;
      end else if (ap_close) begin
        open_reg[bbank_reg] <= 1'b0;
      end
    end
  end

  // Mode registers, refresh and DLL wait.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= MODE_RST;
      ext_reg <= EXT_RST;
      ref_cnt_reg <= '0;
      self_ref_reg <= 1'b0;
      dll_cnt_reg <= 8'h00;
    end else begin
      if (lmr_base && mode_ok) begin
        mode_reg <= a & ~(ADDR_W'(1) << MR_DLLRST_BIT);
      end
      if (lmr_ext) begin
        ext_reg <= a;
      end
      if (c_ref || c_sref) begin
        ref_cnt_reg <= ref_cnt_reg + ROW_W'(1);
      end
      if (c_sref) begin
        self_ref_reg <= 1'b1;
      end else if (sref_exit) begin
        self_ref_reg <= 1'b0;
      end
      if (sref_exit) begin
        ext_reg[EMR_DLL_DIS_BIT] <= 1'b0;
      end
      if (dll_load) begin
        dll_cnt_reg <= 8'(DLL_WAIT_CYC);
      end else if (dll_cnt_reg != 8'h00) begin
        dll_cnt_reg <= dll_cnt_reg - 8'h01;
      end
    end
  end

  // Memory-side outputs; write beats carry the mask sampled with them.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_dly_reg <= 1'b0;
      col_dly_reg <= '0;
      bank_dly_reg <= 2'h0;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_col <= '0;
      mem_bank <= 2'h0;
      mem_act <= 1'b0;
      mem_row <= '0;
      mem_ref <= 1'b0;
      dll_reset <= 1'b0;
    end else begin
      rd_dly_reg <= busy && is_rd_reg;
      col_dly_reg <= beat_col;
      bank_dly_reg <= bbank_reg;
      mem_rd <= lat_long ? rd_dly_reg : busy && is_rd_reg;
      mem_wr <= busy && !is_rd_reg && !sync2_reg.dm;
      mem_col <= (lat_long && !(busy && !is_rd_reg)) ? col_dly_reg : beat_col;
      mem_bank <= (lat_long && !(busy && !is_rd_reg)) ? bank_dly_reg : bbank_reg;
      mem_act <= c_act;
      mem_row <= c_act ? a[ROW_W-1:0] : ref_cnt_reg;
      mem_ref <= c_ref;
      dll_reset <= dll_rst_go;
    end
  end

  // AXI4-Lite slave: address and data taken in either order.
  wire aw_have = aw_hold_reg || s_axi_awvalid;
  wire w_have = w_hold_reg || s_axi_wvalid;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire [4:0] wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire wa_ok = wa == OFF_CTRL || wa == OFF_ERR;
  wire err_clr_go = wr_fire && wa == OFF_ERR && wstrb_reg[0];
  wire ra_ok = s_axi_araddr == OFF_CTRL || s_axi_araddr == OFF_STAT ||
               s_axi_araddr == OFF_MODE || s_axi_araddr == OFF_EXT ||
               s_axi_araddr == OFF_ERR;
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h00000000;
    unique case (s_axi_araddr)
      OFF_CTRL: rd_word[CTRL_EN_BIT] = ctrl_en_reg;
      OFF_STAT: rd_word[9:0] = {busy, self_ref_reg, dll_cnt_reg == 8'h00, dll_ready, 2'h0, open_reg};
      OFF_MODE: rd_word[ADDR_W-1:0] = mode_reg;
      OFF_EXT: rd_word[ADDR_W-1:0] = ext_reg;
      OFF_ERR: rd_word[3:0] = err_reg;
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 5'h00;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      ctrl_en_reg <= CTRL_EN_RST;
      err_reg <= 4'h0;
    end else begin
      s_axi_awready <= !aw_hold_reg && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_hold_reg && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (aw_hold_reg && w_hold_reg && !s_axi_bvalid) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
        if (wa == OFF_CTRL && wstrb_reg[0]) begin
          ctrl_en_reg <= wd[CTRL_EN_BIT];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // A new error in the clearing cycle survives the clear.
      err_reg <= (err_reg & ~(err_clr_go && aw_hold_reg && w_hold_reg ? wd[3:0] : 4'h0))
                 | err_set;
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= ra_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  a_act_opens: assert property (@(posedge aclk) disable iff (!aresetn)
    c_act |=> open_reg[$past(ba)])
    else $error("ACTIVE did not open the bank");
  a_pre_all: assert property (@(posedge aclk) disable iff (!aresetn)
    c_pre && a[AUTO_PRE_BIT] |=> open_reg == '0)
    else $error("precharge all left a bank open");
  a_nop_still: assert property (@(posedge aclk) disable iff (!aresetn)
    kind == CMD_NOP && !ap_close |=> $stable(open_reg) && $stable(mode_reg))
    else $error("NOP changed bank or mode state");
  a_dllrst_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    dll_rst_go |=> !mode_reg[MR_DLLRST_BIT] && dll_reset)
    else $error("DLL reset bit stored or pulse missing");
  a_ext_loaded: assert property (@(posedge aclk) disable iff (!aresetn)
    lmr_ext && !sref_exit |=> ext_reg == $past(a))
    else $error("extended register not loaded");
  a_idle_error: assert property (@(posedge aclk) disable iff (!aresetn)
    c_rd && !bank_ok |=> err_reg[ERR_IDLE] && !busy)
    else $error("read to idle bank not flagged");
  a_rd_lat_two: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_go && !lat_long && !c_bt ##1 !bt_ok |=> mem_rd)
    else $error("read data not at latency two");
  a_dll_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    dll_load |=> dll_cnt_reg == 8'(DLL_WAIT_CYC) && !dll_ready)
    else $error("DLL wait not started");
  a_mask_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
    busy && !is_rd_reg && sync2_reg.dm |=> !mem_wr)
    else $error("masked write word stored");
endmodule

// >>> test/ddrcm_ctrl_model.sv
// Purpose: Memory controller model that drives the rank's command pins.
// Assumes: The bench calls issue just after a rising edge, one command at a time.
// Notes: Strobes are {cs_n, ras_n, cas_n, we_n}.
`timescale 1ns/1ps
module ddrcm_ctrl_model
(
  input wire logic aclk,
  output ddrcm_pkg::ddrcm_cmd_s cmd_pins
);
  import ddrcm_pkg::*;
  initial cmd_pins = {4'hF, 1'b1, 1'b0, 2'h0, 13'h0000};
  // Each command stands one cycle, then the rank is deselected for a cycle.
  // The bank and address pins flip while deselected; ras_n, cas_n and we_n stay high, so that cycle decodes as NOP.
  task issue(input logic [3:0] s, input logic [1:0] ba, input logic [12:0] a, input logic dm);
    cmd_pins <= {s, 1'b1, dm, ba, a};
    @(posedge aclk);
    cmd_pins <= {4'hF, 1'b1, dm, ~ba, ~a};
    @(posedge aclk);
  endtask
  // Clock enable low keeps the rank in self refresh; a deselect with it high leaves.
  task sref(input logic enter);
    if (enter) cmd_pins <= {4'h1, 1'b0, 1'b0, 2'h0, 13'h0000};
    else cmd_pins <= {4'hF, 1'b1, 1'b0, 2'h0, 13'h0000};
    @(posedge aclk);
  endtask
endmodule

// >>> test/ddrcm_top_tb.sv
// Purpose: Self-checking bench for the DDR command and mode logic.
// Assumes: Commands come from the controller model; registers over AXI4-Lite.
// Notes: Beat latencies count edges after the model's two-cycle issue.
`timescale 1ns/1ps
module ddrcm_top_tb;
  import ddrcm_pkg::*;
  logic aclk, aresetn, mem_rd, mem_wr, mem_act, mem_ref, dll_reset;
  ddrcm_cmd_s cmd_pins;
  logic [1:0] mem_bank, bresp, rresp, rsp;
  logic [9:0] mem_col;
  logic [12:0] mem_row;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int error_cnt = 0;
  int n_checks = 0;
  wire [2:0] pls = {dll_reset, mem_ref, mem_act};

  ddrcm_ctrl_model ctrl_u (.aclk(aclk), .cmd_pins(cmd_pins));
  ddrcm_top dut_u (.aclk(aclk), .aresetn(aresetn), .cmd_pins(cmd_pins), .mem_bank(mem_bank),
    .mem_col(mem_col), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_act(mem_act), .mem_row(mem_row),
    .mem_ref(mem_ref), .dll_reset(dll_reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tmo;
    error_cnt++;
    $display("ERROR t=%0t wait limit used up", $time);
    report_and_stop();
  endtask

  task chk(input logic [39:0] got, input logic [39:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] st,
              output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) tmo();
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task axi_rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) tmo();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
    axi_rd(a, rd_d, rsp);
    chk({rsp, rd_d & m}, {RESP_OKAY, e}, "register");
  endtask

  task cmd(input logic [3:0] s, input logic [1:0] ba, input logic [12:0] a, input logic dm);
    ctrl_u.issue(s, ba, a, dm);
    repeat (4) @(posedge aclk);
  endtask

  task pulse(input int w);
    int k;
    for (k = 0; k < 12 && pls[w] !== 1'b1; k++) @(posedge aclk);
    if (k == 12) tmo();
  endtask

  function automatic logic [9:0] ecol(input logic [9:0] s, input int bl, input logic il,
                                      input int i);
    logic [9:0] m;
    m = 10'(bl - 1);
    return (s & ~m) | ((il ? (s ^ 10'(i)) : (s + 10'(i))) & m);
  endfunction

  task burst(input logic wr, input logic [1:0] b, input logic [9:0] c, input int bl,
             input logic il, input int lat);
    int k;
    ctrl_u.issue(wr ? 4'h4 : 4'h5, b, {3'h0, c}, 1'b0);
    for (k = 0; k < 20 && (wr ? mem_wr : mem_rd) !== 1'b1; k++) @(posedge aclk);
    if (k == 20) tmo();
    chk(k, lat, "latency");
    for (int i = 0; i < bl; i++) begin
      chk({wr ? mem_wr : mem_rd, mem_bank, mem_col}, {1'b1, b, ecol(c, bl, il, i)}, "beat");
      @(posedge aclk);
    end
    chk(mem_rd | mem_wr, 1'b0, "burst end");
    repeat (3) @(posedge aclk);
  endtask

  task t_regs;
    rd_chk(OFF_CTRL, 32'h1, 32'(CTRL_EN_RST));
    rd_chk(OFF_MODE, 32'hFFFFFFFF, 32'(MODE_RST));
    rd_chk(OFF_EXT, 32'hFFFFFFFF, 32'(EXT_RST));
    axi_rd(5'h14, rd_d, rsp);
    chk({rsp, rd_d}, {RESP_SLVERR, 32'h0}, "unmapped read");
    axi_wr(OFF_MODE, 32'h1, 4'hF, rsp);
    chk(rsp, RESP_SLVERR, "read-only write");
    rd_chk(OFF_MODE, 32'hFFFFFFFF, 32'(MODE_RST));
    $display("t_regs done");
  endtask

  task t_dll;
    cmd(4'h0, BA_EXT, 13'h0000, 1'b0);
    rd_chk(OFF_EXT, 32'h1, 32'h0);
    ctrl_u.issue(4'h0, BA_MODE, {OP_DLLRST, LAT_CODE_2, 1'b0, BL_CODE_4}, 1'b0);
    pulse(2);
    chk(dll_reset, 1'b1, "dll reset pulse");
    repeat (4) @(posedge aclk);
    rd_chk(OFF_MODE, 32'h1FFF, 32'({LAT_CODE_2, 1'b0, BL_CODE_4}));
    rd_chk(OFF_STAT, 32'h40, 32'h0);
    cmd(4'h0, BA_MODE, {OP_NORMAL, LAT_CODE_2, 1'b0, BL_CODE_4}, 1'b0);
    repeat (DLL_WAIT_CYC) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h40, 32'h40);
    $display("t_dll done");
  endtask

  task t_bank;
    ctrl_u.issue(4'h3, 2'h1, 13'h1ABC, 1'b0);
    pulse(0);
    chk(mem_row, 13'h1ABC, "row");
    repeat (3) @(posedge aclk);
    rd_chk(OFF_STAT, 32'hF, 32'h2);
    ctrl_u.issue(4'h5, 2'h2, 13'h0000, 1'b0);
    repeat (10) begin
      @(posedge aclk);
      chk(mem_rd, 1'b0, "read of idle bank");
    end
    rd_chk(OFF_ERR, 32'h1, 32'h1);
    axi_wr(OFF_ERR, 32'hF, 4'hE, rsp);
    rd_chk(OFF_ERR, 32'h1, 32'h1);
    axi_wr(OFF_ERR, 32'hF, 4'h1, rsp);
    rd_chk(OFF_ERR, 32'hF, 32'h0);
    $display("t_bank done");
  endtask

  task t_order;
    logic [6:0] m7;
    for (int j = 0; j < 6; j++) begin
      m7 = {j[0] ? LAT_CODE_25 : LAT_CODE_2, j[0], 3'(j / 2 + 1)};
      // Every bank is closed before each mode load, so the bank is reopened for each burst.
      cmd(4'h2, 2'h0, 13'h0400, 1'b0);
      cmd(4'h0, BA_MODE, {OP_NORMAL, m7}, 1'b0);
      rd_chk(OFF_MODE, 32'h1FFF, 32'(m7));
      cmd(4'h3, 2'h1, 13'h0000, 1'b0);
      burst(1'b0, 2'h1, 10'h2F5, 2 << (j / 2), j[0], j[0] ? 4 : 3);
    end
    burst(1'b1, 2'h1, 10'h2F5, 8, 1'b1, 3);
    $display("t_order done");
  endtask

  task t_mask;
    ctrl_u.issue(4'h4, 2'h1, 13'h0004, 1'b1);
    ctrl_u.issue(4'h6, 2'h1, 13'h0000, 1'b1);
    repeat (12) begin
      @(posedge aclk);
      chk(mem_wr, 1'b0, "masked word");
    end
    rd_chk(OFF_ERR, 32'h2, 32'h2);
    axi_wr(OFF_ERR, 32'hF, 4'h1, rsp);
    $display("t_mask done");
  endtask

  task t_misc;
    ctrl_u.issue(4'h1, 2'h0, 13'h0000, 1'b0);
    pulse(1);
    chk(mem_ref, 1'b1, "refresh");
    chk(mem_row, 13'h0000, "refresh row");
    ctrl_u.issue(4'h1, 2'h0, 13'h0000, 1'b0);
    pulse(1);
    chk(mem_row, 13'h0001, "refresh row step");
    cmd(4'h7, 2'h2, 13'h1FFF, 1'b0);
    cmd(4'h8, 2'h3, 13'h1FFF, 1'b0);
    rd_chk(OFF_ERR, 32'hF, 32'h0);
    rd_chk(OFF_STAT, 32'hF, 32'h2);
    cmd(4'h0, 2'h2, 13'h0000, 1'b0);
    rd_chk(OFF_ERR, 32'h4, 32'h4);
    rd_chk(OFF_MODE, 32'h1FFF, 32'({LAT_CODE_25, 1'b1, BL_CODE_8}));
    axi_wr(OFF_CTRL, 32'h0, 4'h1, rsp);
    cmd(4'h3, 2'h0, 13'h0000, 1'b0);
    rd_chk(OFF_STAT, 32'hF, 32'h2);
    axi_wr(OFF_CTRL, 32'h1, 4'h1, rsp);
    cmd(4'h3, 2'h3, 13'h0000, 1'b0);
    cmd(4'h2, 2'h3, 13'h0000, 1'b0);
    rd_chk(OFF_STAT, 32'hF, 32'h2);
    cmd(4'h3, 2'h0, 13'h0000, 1'b0);
    cmd(4'h2, 2'h2, 13'h0400, 1'b0);
    rd_chk(OFF_STAT, 32'hF, 32'h0);
    $display("t_misc done");
  endtask

  task t_sref;
    cmd(4'h0, BA_EXT, 13'h0001, 1'b0);
    ctrl_u.sref(1'b1);
    repeat (4) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h100, 32'h100);
    ctrl_u.sref(1'b0);
    repeat (4) @(posedge aclk);
    rd_chk(OFF_STAT, 32'h1C0, 32'h0);
    rd_chk(OFF_EXT, 32'h1, 32'h0);
    $display("t_sref done");
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_dll();
    t_bank();
    t_order();
    t_mask();
    t_misc();
    t_sref();
    report_and_stop();
  end
endmodule
